/* File: logic/slpt_top.sv */
// Lane buffer status, sync error pulse and per-lane pattern test of the receiver.
//
// Contract
// - Eight read-only lane buffer empty flags.
// - Sync low width code: half, one, two cycles.
// - Sync error at multiframe end after errors.
// - Eight per-lane pattern test enables.
// - Lane select picks reported error count.
// - Pattern code picks PRBS7, PRBS15, PRBS31.
// - Run bit runs test; zero stops it.
// - Clear bit resets sequencer and counters.
// - Count above threshold sets lane failure.
// - Threshold from three ascending byte registers.
// - Count low and middle bytes readable.
// - Count top byte at following register.
// - Per-lane pass flags, reset all ones.
// - Eight read-only lane buffer full flags.
`timescale 1ns/1ps
`default_nettype none
`include "slpt_defs.svh"
module slpt_top #(
   parameter int unsigned PCLK_DIV = 4  // Clock cycles per link clock cycle.
) (
   // Clock and reset.
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   // Byte-wide register port.
   input  wire logic                    reg_wr_en,
   input  wire logic                    reg_rd_en,
   input  wire logic [`SLPT_AW-1:0]     reg_addr,
   input  wire logic [7:0]              reg_wdata,
   output var  logic [7:0]              reg_rd_data,
   // Lane receive buffer status.
   input  wire logic [`SLPT_LANES-1:0]  lane_buf_empty,
   input  wire logic [`SLPT_LANES-1:0]  lane_buf_full,
   // Received lane bits.
   input  wire logic [`SLPT_LANES-1:0]  lane_bit,
   input  wire logic [`SLPT_LANES-1:0]  lane_bit_valid,
   // Link character error and multiframe events.
   input  wire logic [1:0]              link_char_err,
   input  wire logic [1:0]              link_mf_end,
   // Sync outputs, low during an error pulse.
   output var  logic                    link0_sync_request_out,
   output var  logic                    link1_sync_request_out,
   // Serdes sync clock select level.
   output var  logic                    sync_clock_select
);

   // ----------------------------------------------------------------
   // Constants.
   // ----------------------------------------------------------------
   // Half a link cycle is rounded down to whole clock cycles, never below one.
   localparam logic [`SLPT_SW-1:0] DUR_HALF =
      (PCLK_DIV < 2) ? `SLPT_SW'(1) : `SLPT_SW'(PCLK_DIV / 2);
   localparam logic [`SLPT_SW-1:0] DUR_ONE  = `SLPT_SW'(PCLK_DIV);
   localparam logic [`SLPT_SW-1:0] DUR_TWO  = `SLPT_SW'(2 * PCLK_DIV);
   // Reset value of the whole state record.
   localparam slpt_pkg::slpt_vars_type RST = '{
      st:      slpt_pkg::SLPT_ST_IDLE,
      pat:     slpt_pkg::SLPT_PAT_7,
      pass:    `SLPT_PASS_RST,
      sync:    `SLPT_SYNC_RST,
      default: '0
   };

   // ----------------------------------------------------------------
   // State record.
   // ----------------------------------------------------------------
   slpt_pkg::slpt_vars_type q;          // Registered state.
   slpt_pkg::slpt_vars_type d;          // Next state.
   logic [`SLPT_LANES-1:0]  exp_bit;    // Expected bit per lane.
   logic [`SLPT_LANES-1:0]  chk_on;     // Lane compares this cycle.
   logic [`SLPT_LANES-1:0]  miss;       // Lane saw a wrong bit.
   logic [`SLPT_LANES-1:0]  over;       // Lane count above threshold.
   logic [1:0]              fire;       // Sync error pulse starts.
   logic [`SLPT_SW-1:0]     dur_cyc;    // Selected pulse width.

   // ----------------------------------------------------------------
   // Per-lane checker.
   // ----------------------------------------------------------------
   // The checker is self-seeding: the expected bit comes from the lane's
   // own received history, so no lock search is needed; a single bad bit
   // then counts up to three times, which is the usual price of this.
   for (genvar l = 0; l < `SLPT_LANES; l++) begin : g_lane
      // Tap pair of the selected polynomial.
      assign exp_bit[l] =
         (q.pat == slpt_pkg::SLPT_PAT_7)  ?
            q.hist[l][`SLPT_T7A] ^ q.hist[l][`SLPT_T7B] :
         (q.pat == slpt_pkg::SLPT_PAT_15) ?
            q.hist[l][`SLPT_T15A] ^ q.hist[l][`SLPT_T15B] :
            q.hist[l][`SLPT_T31A] ^ q.hist[l][`SLPT_T31B];
      // Only a running, enabled lane with a valid bit takes part.
      assign chk_on[l] = (q.st == slpt_pkg::SLPT_ST_RUN) & q.en[l]
                         & lane_bit_valid[l];
      // Comparison starts once the history holds a full sequence.
      assign miss[l] = chk_on[l] & (lane_bit[l] ^ exp_bit[l])
                       & (q.fill[l] == `SLPT_FILL_MAX)
                       & (q.pat != slpt_pkg::SLPT_PAT_NONE);
      assign over[l] = q.cnt[l] > q.thr;
   end

   // ----------------------------------------------------------------
   // Sync pulse width decode.
   // ----------------------------------------------------------------
   // The unused code falls back to the longest width.
   always_comb begin
      case (q.dur)
         2'h0:    dur_cyc = DUR_HALF;
         2'h1:    dur_cyc = DUR_ONE;
         default: dur_cyc = DUR_TWO;
      endcase
   end

   // A sync error fires at multiframe end if any error was seen during
   // that multiframe, including one arriving on the final cycle.
   assign fire = link_mf_end & (q.seen | link_char_err);

   // ----------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      // Register writes.
      if (reg_wr_en) begin
         case (reg_addr)
            `SLPT_A_SYNCGEN: d.dur = reg_wdata[`SLPT_F_DUR];
            `SLPT_A_CLKSEL:  d.clk_sel = reg_wdata[`SLPT_B_CLKSEL];
            `SLPT_A_TEST_EN: d.en = reg_wdata;
            `SLPT_A_CTRL: begin
               d.sel = reg_wdata[`SLPT_F_SEL];
               d.pat = slpt_pkg::slpt_pat_type'(reg_wdata[`SLPT_F_PAT]);
               d.run = reg_wdata[`SLPT_B_RUN];
               d.clr = reg_wdata[`SLPT_B_CLR];
            end
            `SLPT_A_THR0: d.thr[7:0]   = reg_wdata;
            `SLPT_A_THR1: d.thr[15:8]  = reg_wdata;
            `SLPT_A_THR2: d.thr[23:16] = reg_wdata;
            default: d.thr = q.thr;                              // Others ignore writes.
         endcase
      end
      // Register reads; unmapped and reserved bits read zero.
      if (reg_rd_en) begin
         d.rdata = '0;
         case (reg_addr)
            `SLPT_A_FULL:    d.rdata = lane_buf_full;
            `SLPT_A_EMPTY:   d.rdata = lane_buf_empty;
            `SLPT_A_SYNCGEN: d.rdata[`SLPT_F_DUR] = q.dur;
            `SLPT_A_CLKSEL:  d.rdata[`SLPT_B_CLKSEL] = q.clk_sel;
            `SLPT_A_TEST_EN: d.rdata = q.en;
            `SLPT_A_CTRL: begin
               d.rdata[`SLPT_F_SEL] = q.sel;
               d.rdata[`SLPT_F_PAT] = q.pat;
               d.rdata[`SLPT_B_RUN] = q.run;
               d.rdata[`SLPT_B_CLR] = q.clr;
            end
            `SLPT_A_THR0: d.rdata = q.thr[7:0];
            `SLPT_A_THR1: d.rdata = q.thr[15:8];
            `SLPT_A_THR2: d.rdata = q.thr[23:16];
            `SLPT_A_CNT0: d.rdata = q.cnt[q.sel][7:0];
            `SLPT_A_CNT1: d.rdata = q.cnt[q.sel][15:8];
            `SLPT_A_CNT2: d.rdata = q.cnt[q.sel][23:16];
            `SLPT_A_PASS: d.rdata = q.pass;
            default:      d.rdata = '0;
         endcase
      end
      // Test sequencer; the clear bit overrides the run bit.
      case (q.st)
         slpt_pkg::SLPT_ST_IDLE: begin
            if (q.clr) begin
               d.st = slpt_pkg::SLPT_ST_CLEAR;
            end else if (q.run) begin
               d.st = slpt_pkg::SLPT_ST_RUN;
            end
         end
         slpt_pkg::SLPT_ST_RUN: begin
            if (q.clr) begin
               d.st = slpt_pkg::SLPT_ST_CLEAR;
            end else if (!q.run) begin
               d.st = slpt_pkg::SLPT_ST_IDLE;
            end
         end
         slpt_pkg::SLPT_ST_CLEAR: begin
            // Held here while the clear bit stays set.
            if (!q.clr) begin
               d.st = slpt_pkg::SLPT_ST_IDLE;
            end
         end
         default: d.st = slpt_pkg::SLPT_ST_IDLE;
      endcase
      // Lane history, counters and pass flags.
      for (int l = 0; l < `SLPT_LANES; l++) begin
         if (q.st == slpt_pkg::SLPT_ST_CLEAR) begin
            d.hist[l] = '0;
            d.fill[l] = '0;
            d.cnt[l]  = '0;
            d.pass[l] = 1'b1;
         end else begin
            if (chk_on[l]) begin
               d.hist[l] = {q.hist[l][`SLPT_HW-2:0], lane_bit[l]};
               if (q.fill[l] != `SLPT_FILL_MAX) begin
                  d.fill[l] = q.fill[l] + `SLPT_FW'(1);
               end
            end
            // The counter saturates rather than wrapping to zero.
            if (miss[l] && q.cnt[l] != `SLPT_CNT_MAX) begin
               d.cnt[l] = q.cnt[l] + `SLPT_CW'(1);
            end
            // Failure is sticky until the next clear.
            if (over[l]) begin
               d.pass[l] = 1'b0;
            end
         end
      end
      // Sync error tracking and pulse timing per link.
      for (int k = 0; k < 2; k++) begin
         // Multiframe end closes the window; a same-cycle error is
         // already counted into this window by the fire term.
         if (link_mf_end[k]) begin
            d.seen[k] = 1'b0;
         end else if (link_char_err[k]) begin
            d.seen[k] = 1'b1;
         end
         if (fire[k]) begin
            d.slow[k] = dur_cyc;
         end else if (q.slow[k] != '0) begin
            d.slow[k] = q.slow[k] - `SLPT_SW'(1);
         end
         d.sync[k] = (d.slow[k] == '0);
      end
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from flip-flops.
   assign reg_rd_data            = q.rdata;
   assign link0_sync_request_out = q.sync[0];
   assign link1_sync_request_out = q.sync[1];
   assign sync_clock_select      = q.clk_sel;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_fire0;
      link_mf_end[0] && (q.seen[0] || link_char_err[0]);
   endsequence
   sequence s_quiet0;
      link_mf_end[0] && !q.seen[0] && !link_char_err[0];
   endsequence

   chk_empty_read: assert property (
      reg_rd_en && reg_addr == `SLPT_A_EMPTY |=> reg_rd_data == $past(lane_buf_empty))
      else $error("empty flags read back wrong");
   chk_full_read: assert property (
      reg_rd_en && reg_addr == `SLPT_A_FULL |=> reg_rd_data == $past(lane_buf_full))
      else $error("full flags read back wrong");
   chk_sync_width: assert property (
      s_fire0 |=> !link0_sync_request_out && q.slow[0] == $past(dur_cyc))
      else $error("sync pulse width not loaded");
   chk_sync_release: assert property (
      q.slow[0] == `SLPT_SW'(1) && !link_mf_end[0] |=> link0_sync_request_out)
      else $error("sync pulse not released");
   chk_mf_quiet: assert property (
      s_quiet0 ##0 link0_sync_request_out |=> link0_sync_request_out)
      else $error("sync error without a character error");
   chk_lane_off: assert property (
      !q.en[0] && q.st != slpt_pkg::SLPT_ST_CLEAR |=> $stable(q.cnt[0]))
      else $error("disabled lane counted");
   chk_stop_hold: assert property (
      q.st == slpt_pkg::SLPT_ST_IDLE |=> $stable(q.cnt))
      else $error("counters moved while stopped");
   chk_count_step: assert property (
      miss[0] && q.cnt[0] != `SLPT_CNT_MAX
      |=> q.cnt[0] == `SLPT_CW'($past(q.cnt[0]) + `SLPT_CW'(1)))
      else $error("mismatch not counted");
   chk_clear_zero: assert property (
      q.st == slpt_pkg::SLPT_ST_CLEAR |=> q.cnt == '0 && q.pass == `SLPT_PASS_RST)
      else $error("clear left counters");
   // A clear bit already stored may move the sequencer to CLEAR next edge, which
   // restores the flag on the edge after; such cycles cannot promise two low cycles.
   chk_pass_fail: assert property (
      over[0] && q.st != slpt_pkg::SLPT_ST_CLEAR && !q.clr |=> !q.pass[0] [*2])
      else $error("failure flag not set");
   chk_thr_write: assert property (
      reg_wr_en && reg_addr == `SLPT_A_THR1 |=> q.thr[15:8] == $past(reg_wdata))
      else $error("threshold middle byte not stored");
   chk_cnt_low: assert property (
      reg_rd_en && reg_addr == `SLPT_A_CNT0 |=> reg_rd_data == $past(q.cnt[q.sel][7:0]))
      else $error("count low byte wrong");
   chk_cnt_top: assert property (
      reg_rd_en && reg_addr == `SLPT_A_CNT2
      |=> reg_rd_data == $past(q.cnt[q.sel][23:16]))
      else $error("count top byte wrong");

endmodule : slpt_top
`default_nettype wire

/* File: logic/slpt_defs.svh */
// Address map, field positions, reset values and widths of the lane test block.
`ifndef SLPT_DEFS_SVH
`define SLPT_DEFS_SVH
// ----------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------
`define SLPT_A_FULL     12'h30C
`define SLPT_A_EMPTY    12'h30D
`define SLPT_A_SYNCGEN  12'h312
`define SLPT_A_CLKSEL   12'h314
`define SLPT_A_TEST_EN  12'h315
`define SLPT_A_CTRL     12'h316
`define SLPT_A_THR0     12'h317
`define SLPT_A_THR1     12'h318
`define SLPT_A_THR2     12'h319
`define SLPT_A_CNT0     12'h31A
`define SLPT_A_CNT1     12'h31B
`define SLPT_A_CNT2     12'h31C
`define SLPT_A_PASS     12'h31D
// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define SLPT_F_DUR      5:4
`define SLPT_F_SEL      6:4
`define SLPT_F_PAT      3:2
`define SLPT_B_RUN      1
`define SLPT_B_CLR      0
`define SLPT_B_CLKSEL   0
// ----------------------------------------------------------------
// Widths, taps and reset values.
// ----------------------------------------------------------------
`define SLPT_AW         12
`define SLPT_LANES      8
`define SLPT_HW         31
`define SLPT_CW         24
`define SLPT_SW         8
`define SLPT_FW         5
`define SLPT_FILL_MAX   5'h1F
`define SLPT_CNT_MAX    24'hFFFFFF
`define SLPT_PASS_RST   8'hFF
`define SLPT_SYNC_RST   2'h3
`define SLPT_T7A        6
`define SLPT_T7B        5
`define SLPT_T15A       14
`define SLPT_T15B       13
`define SLPT_T31A       30
`define SLPT_T31B       27
`endif

/* File: logic/slpt_pkg.sv */
// Types shared by the lane test block: state codes, pattern codes, state record.
`default_nettype none
`include "slpt_defs.svh"
package slpt_pkg;
   // Test sequencer states, one-hot.
   typedef enum logic [2:0] {
      SLPT_ST_IDLE  = 3'h1,
      SLPT_ST_RUN   = 3'h2,
      SLPT_ST_CLEAR = 3'h4
   } slpt_state_type;
   // Pattern select codes.
   typedef enum logic [1:0] {
      SLPT_PAT_7    = 2'h0,
      SLPT_PAT_15   = 2'h1,
      SLPT_PAT_31   = 2'h2,
      SLPT_PAT_NONE = 2'h3
   } slpt_pat_type;
   // Every flip-flop of the block.
   typedef struct packed {
      slpt_state_type                         st;
      logic [1:0]                             dur;
      logic                                   clk_sel;
      logic [`SLPT_LANES-1:0]                 en;
      logic [2:0]                             sel;
      slpt_pat_type                           pat;
      logic                                   run;
      logic                                   clr;
      logic [`SLPT_CW-1:0]                    thr;
      logic [`SLPT_LANES-1:0][`SLPT_HW-1:0]   hist;
      logic [`SLPT_LANES-1:0][`SLPT_FW-1:0]   fill;
      logic [`SLPT_LANES-1:0][`SLPT_CW-1:0]   cnt;
      logic [`SLPT_LANES-1:0]                 pass;
      logic [1:0]                             seen;
      logic [1:0][`SLPT_SW-1:0]               slow;
      logic [1:0]                             sync;
      logic [7:0]                             rdata;
   } slpt_vars_type;
endpackage : slpt_pkg
`default_nettype wire

/* File: tb/slpt_lane_src.sv */
// Far-end lane source that sends the selected pseudo-random sequence.
`timescale 1ns/1ps
`default_nettype none
module slpt_lane_src (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Bench control: pattern, send enable and bit flips.
   input  wire logic [1:0] pat,
   input  wire logic       go,
   input  wire logic [7:0] inj,
   // Lanes towards the block.
   output var  logic [7:0] lane_bit,
   output var  logic [7:0] lane_bit_valid
);
   logic [30:0] gen_q; // Sent history, newest bit at index 0.
   logic        nb;    // Next sequence bit.
   // Next bit of the selected sequence, taken from the sent history.
   always_comb begin
      case (pat)
         2'h0:    nb = gen_q[6] ^ gen_q[5];
         2'h1:    nb = gen_q[14] ^ gen_q[13];
         default: nb = gen_q[30] ^ gen_q[27];
      endcase
   end
   // A flip corrupts the line only; the history keeps the true bit.
   always @(negedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gen_q          <= 31'h1;
         lane_bit       <= 8'h00;
         lane_bit_valid <= 8'h00;
      end else if (go) begin
         gen_q          <= {gen_q[29:0], nb};
         lane_bit       <= {8{nb}} ^ inj;
         lane_bit_valid <= 8'hFF;
      end else begin
         // The idle line toggles so that a stale bit is never taken as data.
         lane_bit       <= ~lane_bit;
         lane_bit_valid <= 8'h00;
      end
   end
endmodule : slpt_lane_src
`default_nettype wire

/* File: tb/slpt_top_test.sv */
// Self-checking testbench of the lane test block.
`timescale 1ns/1ps
`default_nettype none
module slpt_top_test;
   localparam int DIV = 4; // Clock cycles per link clock cycle.
   logic        clk, arst_n, reg_wr_en, reg_rd_en, go;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, lane_buf_empty, lane_buf_full, inj;
   logic [1:0]  link_char_err, link_mf_end, pat;
   wire  [7:0]  reg_rd_data, lane_bit, lane_bit_valid;
   wire  [1:0]  sync_o;
   wire         clk_sel;
   int          n_fail = 0;
   int          checked = 0;

   slpt_top #(.PCLK_DIV(DIV)) u_slpt_top (
      .clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data),
      .lane_buf_empty(lane_buf_empty), .lane_buf_full(lane_buf_full),
      .lane_bit(lane_bit), .lane_bit_valid(lane_bit_valid),
      .link_char_err(link_char_err), .link_mf_end(link_mf_end),
      .link0_sync_request_out(sync_o[0]), .link1_sync_request_out(sync_o[1]),
      .sync_clock_select(clk_sel));
   slpt_lane_src u_slpt_lane_src (
      .clk(clk), .arst_n(arst_n), .pat(pat), .go(go), .inj(inj),
      .lane_bit(lane_bit), .lane_bit_valid(lane_bit_valid));

   always #5 clk = ~clk;

   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic close_out();
      if (n_fail == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         n_fail++;
      end
   endtask : chk
   // One byte write; the strobe stands for exactly one edge.
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr_en = 1'b1;
      @(negedge clk); reg_wr_en = 1'b0;
   endtask : wr
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
      @(negedge clk); reg_addr = a; reg_rd_en = 1'b1;
      @(negedge clk); reg_rd_en = 1'b0;
      chk(nm, e, reg_rd_data);
   endtask : rd_chk
   // Sends n lane bits, flipping lanes 0 and 1 twice, far enough apart.
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         go  <= 1'b1;
         inj <= (i == 45 || i == 85) ? 8'h03 : 8'h00;
      end
      @(negedge clk); go <= 1'b0; inj <= 8'h00;
   endtask : send

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk("pass", 12'h31D, 8'hFF);
      rd_chk("ctrl", 12'h316, 8'h00);
      rd_chk("cnt", 12'h31A, 8'h00);
      chk("sync", 8'h03, {6'h0, sync_o});
   endtask : t_reset
   task automatic t_status();
      @(negedge clk); lane_buf_empty = 8'h5A; lane_buf_full = 8'hA5;
      rd_chk("empty", 12'h30D, 8'h5A);
      rd_chk("full", 12'h30C, 8'hA5);
      @(negedge clk); lane_buf_empty = 8'h81; lane_buf_full = 8'h18;
      rd_chk("empty", 12'h30D, 8'h81);
      rd_chk("full", 12'h30C, 8'h18);
   endtask : t_status
   task automatic t_regs();
      wr(12'h317, 8'hA5); wr(12'h318, 8'h5A); wr(12'h319, 8'hC3);
      rd_chk("thr0", 12'h317, 8'hA5);
      rd_chk("thr1", 12'h318, 8'h5A);
      rd_chk("thr2", 12'h319, 8'hC3);
      wr(12'h318, 8'h00); wr(12'h319, 8'h00);
      wr(12'h315, 8'h3C); rd_chk("en", 12'h315, 8'h3C);
      wr(12'h316, 8'hFC); rd_chk("ctrl", 12'h316, 8'h7C);
      wr(12'h316, 8'h00);
      wr(12'h314, 8'hFF); rd_chk("clksel", 12'h314, 8'h01);
      chk("clksel_pin", 8'h01, {7'h0, clk_sel});
      wr(12'h314, 8'h00);
      wr(12'h31D, 8'h00); rd_chk("pass_ro", 12'h31D, 8'hFF);
      rd_chk("unmapped", 12'h320, 8'h00);
      wr(12'h312, 8'hFF); rd_chk("syncgen", 12'h312, 8'h30);
   endtask : t_regs
   // Error then multiframe end gives a low pulse of n cycles; a clean end none.
   task automatic t_sync(input logic [1:0] code, input int n);
      int lo;
      wr(12'h312, {2'h0, code, 4'h0});
      for (int k = 0; k < 2; k++) begin
         @(negedge clk); link_char_err[k] = 1'b1;
         // Link 0 errs a cycle early; link 1 errs in the closing cycle.
         if (k == 0) begin
            @(negedge clk); link_char_err = 2'h0;
         end
         link_mf_end[k] = 1'b1;
         @(negedge clk); link_char_err = 2'h0; link_mf_end = 2'h0;
         lo = 0;
         repeat (20) begin
            if (sync_o[k] === 1'b0) lo++;
            @(negedge clk);
         end
         chk("sync_width", n[7:0], lo[7:0]);
         link_mf_end[k] = 1'b1;
         @(negedge clk); link_mf_end = 2'h0;
         lo = 0;
         repeat (20) begin
            if (sync_o[k] === 1'b0) lo++;
            @(negedge clk);
         end
         chk("sync_clean", 8'h00, lo[7:0]);
      end
   endtask : t_sync
   task automatic t_prbs(input logic [1:0] p, input logic [7:0] t, input logic [7:0] e_cnt,
                         input logic [7:0] e_pass);
      wr(12'h316, 8'h01); wr(12'h316, 8'h00);
      rd_chk("cnt_clr", 12'h31A, 8'h00);
      rd_chk("pass_clr", 12'h31D, 8'hFF);
      wr(12'h317, t); wr(12'h315, 8'h09); pat <= p;
      wr(12'h316, {4'h0, p, 2'h2});
      send(130);
      wr(12'h316, {4'h0, p, 2'h0});
      send(60);
      rd_chk("cnt_lo", 12'h31A, e_cnt);
      rd_chk("cnt_mid", 12'h31B, 8'h00);
      rd_chk("cnt_hi", 12'h31C, 8'h00);
      wr(12'h316, {4'h1, p, 2'h0}); rd_chk("cnt_dis", 12'h31A, 8'h00);
      wr(12'h316, {4'h3, p, 2'h0}); rd_chk("cnt_l3", 12'h31A, 8'h00);
      rd_chk("pass", 12'h31D, e_pass);
   endtask : t_prbs

   // Watchdog: a hang counts as a mismatch and ends the run.
   initial begin
      repeat (50000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      clk = 1'b0; arst_n = 1'b0; reg_wr_en = 1'b0; reg_rd_en = 1'b0; go = 1'b0;
      reg_addr = 12'h000; reg_wdata = 8'h00; lane_buf_empty = 8'h00; lane_buf_full = 8'h00;
      inj = 8'h00; link_char_err = 2'h0; link_mf_end = 2'h0; pat = 2'h0;
      repeat (8) @(posedge clk);
      @(negedge clk); arst_n = 1'b1;
      t_reset();
      t_status();
      t_regs();
      t_sync(2'h0, DIV / 2);
      t_sync(2'h1, DIV);
      t_sync(2'h2, 2 * DIV);
      t_sync(2'h3, 2 * DIV);
      t_prbs(2'h0, 8'h06, 8'h06, 8'hFF);
      t_prbs(2'h1, 8'h05, 8'h06, 8'hFE);
      t_prbs(2'h2, 8'h05, 8'h06, 8'hFE);
      t_prbs(2'h3, 8'h00, 8'h00, 8'hFF);
      close_out();
   end
endmodule : slpt_top_test
`default_nettype wire
